// [hw/adcsq_top.sv]
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_top (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic sleep_in,
    input wire logic special_event_in,
    input wire logic [3:0] compare_mode_in,
    input wire logic [9:0] adc_data_in,
    output logic timer_one_reset_out,
    output logic converter_power_out,
    output logic conv_busy_out,
    output logic [3:0] channel_out,
    output logic vref_sel_out,
    output logic [11:0] analog_select_out,
    output logic irq_out,
    output logic wake_out,
    output logic vector_jump_out,
    output logic [12:0] vector_addr_out
);
    import adcsq_pkg::*;

    localparam logic [6:0] INSTR_LAST = 7'(`ADCSQ_INSTR_CYC - 1);
    localparam logic [6:0] CONV_LAST = 7'(`ADCSQ_CONV_TADS - 1);

    logic [7:0] intctl_reg, intctl_next, pie_reg, pie_next;
    logic [7:0] ans_lo_reg, ans_lo_next, ans_hi_reg, ans_hi_next;
    logic [7:0] ctl0_reg, ctl0_next, ctl1_reg, ctl1_next, rdata_reg, rdata_next;
    adcsq_state_t state_reg, state_next;
    logic [6:0] step_reg, step_next;
    logic go_reg, go_next, flag_reg, flag_next, pdown_reg, pdown_next;
    logic power_reg, power_next, busy_reg, busy_next, irq_reg, irq_next;
    logic wake_reg, wake_next, jump_reg, jump_next, t1rst_reg, t1rst_next;
    logic [12:0] vec_reg, vec_next;
    logic [7:0] res_hi_reg, res_hi_next, res_lo_reg, res_lo_next;
    logic wr_ctl0, wr_clr, rc_sel, trig_start, done, div_restart, tad_tick, irq_armed;

    assign wr_ctl0 = wr_in && addr_in == `ADCSQ_A_CTL0;
    assign wr_clr = wr_in && addr_in == `ADCSQ_A_IRQCLR && wdata_in[`ADCSQ_B_CONV_IRQ];
    // Codes x11 select the dedicated RC oscillator
    assign rc_sel = ctl1_reg[`ADCSQ_B_CS_LO + 1:`ADCSQ_B_CS_LO] == 2'b11;
    assign trig_start = special_event_in && compare_mode_in == `ADCSQ_TRIG_MODE && ctl0_reg[`ADCSQ_B_ON];
    assign done = !rst_in && state_reg == ADCSQ_CONV && tad_tick && step_reg == CONV_LAST;
    assign irq_armed = pie_reg[`ADCSQ_B_CONV_IRQ] && intctl_reg[`ADCSQ_B_PERIPHERAL_IRQ_ENABLE];

    // ==========================================
    // Software registers
    always_comb
    begin
        intctl_next = intctl_reg;
        pie_next = pie_reg;
        ans_lo_next = ans_lo_reg;
        ans_hi_next = ans_hi_reg;
        ctl0_next = ctl0_reg;
        ctl1_next = ctl1_reg;
        rdata_next = 8'h00;
        if (wr_in)
        begin
            case (addr_in)
                `ADCSQ_A_INTCTL: intctl_next = wdata_in;
                `ADCSQ_A_PIE: pie_next = wdata_in;
                `ADCSQ_A_ANSLO: ans_lo_next = wdata_in;
                `ADCSQ_A_ANSHI: ans_hi_next = wdata_in & `ADCSQ_M_ANSHI;
                `ADCSQ_A_CTL0: ctl0_next = wdata_in & `ADCSQ_M_CTL0;
                `ADCSQ_A_CTL1: ctl1_next = wdata_in & `ADCSQ_M_CTL1;
                default: ctl1_next = ctl1_reg;
            endcase
        end
        if (rd_in)
        begin
            case (addr_in)
                `ADCSQ_A_INTCTL: rdata_next = intctl_reg;
                `ADCSQ_A_PIRF: rdata_next = {1'b0, flag_reg, 6'h00};
                `ADCSQ_A_RESH: rdata_next = res_hi_reg;
                `ADCSQ_A_CTL0: rdata_next = {ctl0_reg[7:2], go_reg, ctl0_reg[0]};
                `ADCSQ_A_PIE: rdata_next = pie_reg;
                `ADCSQ_A_ANSLO: rdata_next = ans_lo_reg;
                `ADCSQ_A_ANSHI: rdata_next = ans_hi_reg;
                `ADCSQ_A_RESL: rdata_next = res_lo_reg;
                `ADCSQ_A_CTL1: rdata_next = ctl1_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            intctl_reg <= `ADCSQ_R_INTCTL;
            pie_reg <= `ADCSQ_R_PIE;
            ans_lo_reg <= `ADCSQ_R_ANSLO;
            ans_hi_reg <= `ADCSQ_R_ANSHI;
            ctl0_reg <= `ADCSQ_R_CTL0;
            ctl1_reg <= `ADCSQ_R_CTL1;
            rdata_reg <= 8'h00;
        end
        else
        begin
            intctl_reg <= intctl_next;
            pie_reg <= pie_next;
            ans_lo_reg <= ans_lo_next;
            ans_hi_reg <= ans_hi_next;
            ctl0_reg <= ctl0_next;
            ctl1_reg <= ctl1_next;
            rdata_reg <= rdata_next;
        end
    end

    adcsq_tad_div u_tad_div (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .restart_in(div_restart),
        .sel_in(ctl1_reg[`ADCSQ_B_CS_HI:`ADCSQ_B_CS_LO]),
        .tick_out(tad_tick)
    );

    // ==========================================
    // Conversion sequencer
    always_comb
    begin
        state_next = state_reg;
        step_next = step_reg;
        go_next = go_reg;
        pdown_next = pdown_reg && sleep_in;
        res_hi_next = res_hi_reg;
        res_lo_next = res_lo_reg;
        wake_next = 1'b0;
        jump_next = 1'b0;
        vec_next = 13'h0000;
        div_restart = 1'b0;
        t1rst_next = special_event_in;
        case (state_reg)
            ADCSQ_IDLE:
            begin
                step_next = 7'h00;
                if (go_reg && ctl0_reg[`ADCSQ_B_ON] && !pdown_reg)
                begin
                    // RC start waits an instruction so a sleep can settle the supply
                    state_next = rc_sel ? ADCSQ_DELAY : ADCSQ_CONV;
                    div_restart = !rc_sel;
                end
            end
            ADCSQ_DELAY:
            begin
                step_next = step_reg + 7'h01;
                if (step_reg == INSTR_LAST)
                begin
                    state_next = ADCSQ_CONV;
                    step_next = 7'h00;
                    div_restart = 1'b1;
                end
            end
            ADCSQ_CONV:
            begin
                if (tad_tick)
                    step_next = step_reg + 7'h01;
                if (done)
                begin
                    state_next = ADCSQ_IDLE;
                    go_next = 1'b0;
                    if (ctl0_reg[`ADCSQ_B_JUSTIFY])
                    begin
                        res_hi_next = {6'h00, adc_data_in[9:8]};
                        res_lo_next = adc_data_in[7:0];
                    end
                    else
                    begin
                        res_hi_next = adc_data_in[9:2];
                        res_lo_next = {adc_data_in[1:0], 6'h00};
                    end
                    if (sleep_in && irq_armed)
                    begin
                        wake_next = 1'b1;
                        jump_next = intctl_reg[`ADCSQ_B_GIE];
                        vec_next = intctl_reg[`ADCSQ_B_GIE] ? `ADCSQ_VECTOR : 13'h0000;
                    end
                    else if (sleep_in)
                        pdown_next = 1'b1;
                end
            end
            default: state_next = ADCSQ_IDLE;
        endcase
        if (sleep_in && !rc_sel)
            pdown_next = 1'b1;
        if (state_reg != ADCSQ_IDLE && !done &&
            (!ctl0_reg[`ADCSQ_B_ON] || (sleep_in && !rc_sel) || (wr_ctl0 && !wdata_in[`ADCSQ_B_GO])))
        begin
            state_next = ADCSQ_IDLE;
            go_next = 1'b0;
        end
        if (wr_ctl0)
            go_next = wdata_in[`ADCSQ_B_GO];
        if (trig_start)
            go_next = 1'b1;
        // A completion in the clearing cycle keeps the flag
        flag_next = (flag_reg && !wr_clr) || done;
        irq_next = flag_next && pie_reg[`ADCSQ_B_CONV_IRQ];
        power_next = ctl0_next[`ADCSQ_B_ON] && !pdown_next;
        busy_next = state_next != ADCSQ_IDLE;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= ADCSQ_IDLE;
            step_reg <= 7'h00;
            go_reg <= 1'b0;
            flag_reg <= 1'b0;
            pdown_reg <= 1'b0;
            power_reg <= 1'b0;
            busy_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            jump_reg <= 1'b0;
            vec_reg <= 13'h0000;
            t1rst_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            step_reg <= step_next;
            go_reg <= go_next;
            flag_reg <= flag_next;
            pdown_reg <= pdown_next;
            power_reg <= power_next;
            busy_reg <= busy_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            jump_reg <= jump_next;
            vec_reg <= vec_next;
            t1rst_reg <= t1rst_next;
        end
    end

    // Result pair survives reset, so it has no reset branch
    always_ff @(posedge ref_clk_in)
    begin
        res_hi_reg <= res_hi_next;
        res_lo_reg <= res_lo_next;
    end

    assign rdata_out = rdata_reg;
    assign timer_one_reset_out = t1rst_reg;
    assign converter_power_out = power_reg;
    assign conv_busy_out = busy_reg;
    assign channel_out = ctl0_reg[`ADCSQ_B_CHAN_HI:`ADCSQ_B_CHAN_LO];
    assign vref_sel_out = ctl0_reg[`ADCSQ_B_VREF];
    assign analog_select_out = {ans_hi_reg[3:0], ans_lo_reg};
    assign irq_out = irq_reg;
    assign wake_out = wake_reg;
    assign vector_jump_out = jump_reg;
    assign vector_addr_out = vec_reg;

    // ==========================================
    // Checks
    chk_done_clears_go: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (done && !trig_start && !wr_ctl0) |=> !go_reg && !conv_busy_out)
        else $error("go bit not cleared at completion");

    chk_result_justify: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        done |=> (ctl0_reg[7] ? {res_hi_reg[1:0], res_lo_reg} : {res_hi_reg, res_lo_reg[7:6]})
            == $past(adc_data_in))
        else $error("result pair misplaced");

    chk_rc_delay_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (state_reg == ADCSQ_IDLE ##1 state_reg == ADCSQ_DELAY) |-> (state_reg != ADCSQ_CONV)[*4])
        else $error("RC start not delayed");

    chk_sleep_wake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (done && sleep_in && irq_armed) |=> wake_out && vector_jump_out == $past(intctl_reg[7])
            && vector_addr_out == (vector_jump_out ? 13'h0004 : 13'h0000))
        else $error("wake from sleep wrong");

    chk_sleep_power_down: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (done && sleep_in && !irq_armed && !wr_ctl0) |=> !converter_power_out && ctl0_reg[0] == $past(ctl0_reg[0]))
        else $error("no power down after sleep completion");

    chk_sleep_abort: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (sleep_in && !rc_sel && busy_reg && !wr_in) |=> !conv_busy_out && !converter_power_out && !go_reg
            && ctl0_reg[0] == $past(ctl0_reg[0]))
        else $error("sleep did not abort conversion");

    chk_reset_state: assert property (@(posedge ref_clk_in)
        rst_in |=> ctl0_reg == 8'h00 && !converter_power_out && !go_reg && $stable(res_hi_reg)
            && $stable(res_lo_reg) && ans_lo_reg == 8'hff)
        else $error("reset values wrong");

    chk_trigger_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        trig_start |=> go_reg && timer_one_reset_out)
        else $error("trigger did not start conversion");

    chk_trigger_ignored: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (special_event_in && !ctl0_reg[0] && !wr_ctl0 && state_reg == ADCSQ_IDLE)
            |=> timer_one_reset_out && go_reg == $past(go_reg))
        else $error("trigger not ignored while off");

    chk_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (done || (flag_reg && !wr_clr)) |=> flag_reg && irq_out == $past(pie_reg[6]))
        else $error("conversion flag lost");
endmodule

// [hw/adcsq_consts.svh]
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// ==========================================
// Register byte addresses
`define ADCSQ_A_INTCTL 8'h0b
`define ADCSQ_A_PIRF 8'h0c
`define ADCSQ_A_IRQCLR 8'h0d
`define ADCSQ_A_RESH 8'h1e
`define ADCSQ_A_CTL0 8'h1f
`define ADCSQ_A_PIE 8'h8c
`define ADCSQ_A_ANSLO 8'h91
`define ADCSQ_A_ANSHI 8'h93
`define ADCSQ_A_RESL 8'h9e
`define ADCSQ_A_CTL1 8'h9f

// ==========================================
// Field positions
`define ADCSQ_B_JUSTIFY 7
`define ADCSQ_B_VREF 6
`define ADCSQ_B_CHAN_HI 5
`define ADCSQ_B_CHAN_LO 2
`define ADCSQ_B_GO 1
`define ADCSQ_B_ON 0
`define ADCSQ_B_CS_HI 6
`define ADCSQ_B_CS_LO 4
`define ADCSQ_B_CONV_IRQ 6
`define ADCSQ_B_GIE 7
`define ADCSQ_B_PERIPHERAL_IRQ_ENABLE 6

// ==========================================
// Reset values and write masks
`define ADCSQ_R_INTCTL 8'h00
`define ADCSQ_R_CTL0 8'h00
`define ADCSQ_R_PIE 8'h00
`define ADCSQ_R_ANSLO 8'hff
`define ADCSQ_R_ANSHI 8'h0f
`define ADCSQ_R_CTL1 8'h00
`define ADCSQ_M_ANSHI 8'h0f
`define ADCSQ_M_CTL1 8'h70
`define ADCSQ_M_CTL0 8'hfd

// ==========================================
// Conversion clock divisors per select code
`define ADCSQ_DIV_C0 2
`define ADCSQ_DIV_C1 8
`define ADCSQ_DIV_C2 32
`define ADCSQ_DIV_C4 4
`define ADCSQ_DIV_C5 16
`define ADCSQ_DIV_C6 64

// ==========================================
// Timing
`define ADCSQ_CLK_NS 50
`define ADCSQ_INSTR_NS 200
`define ADCSQ_INSTR_CYC ((`ADCSQ_INSTR_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`define ADCSQ_RC_TAD_NS 2000
`define ADCSQ_RC_TAD_CYC ((`ADCSQ_RC_TAD_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`define ADCSQ_CONV_TADS 11
`define ADCSQ_TRIG_MODE 4'hb
`define ADCSQ_VECTOR 13'h0004

`endif

// [hw/adcsq_pkg.sv]
package adcsq_pkg;
    typedef enum logic [1:0] {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_DELAY = 2'b01,
        ADCSQ_CONV = 2'b10
    } adcsq_state_t;
    typedef logic [2:0] adcsq_clksel_t;
endpackage

// [hw/adcsq_tad_div.sv]
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_tad_div (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic restart_in,
    input wire adcsq_pkg::adcsq_clksel_t sel_in,
    output logic tick_out
);
    import adcsq_pkg::*;

    logic [6:0] count_reg, count_next, last;
    logic tick_reg, tick_next;

    // ==========================================
    // Period select
    always_comb
    begin
        case (sel_in)
            3'h0: last = 7'(`ADCSQ_DIV_C0 - 1);
            3'h1: last = 7'(`ADCSQ_DIV_C1 - 1);
            3'h2: last = 7'(`ADCSQ_DIV_C2 - 1);
            3'h4: last = 7'(`ADCSQ_DIV_C4 - 1);
            3'h5: last = 7'(`ADCSQ_DIV_C5 - 1);
            3'h6: last = 7'(`ADCSQ_DIV_C6 - 1);
            default: last = 7'(`ADCSQ_RC_TAD_CYC - 1);
        endcase
        count_next = (restart_in || count_reg >= last) ? 7'h00 : count_reg + 7'h01;
        tick_next = !restart_in && count_reg >= last;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            count_reg <= 7'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;

    chk_div_two_period: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ((tick_reg && sel_in == 3'h0 && !restart_in) ##1 (!restart_in && sel_in == 3'h0)) |=> tick_reg)
        else $error("divide-by-two tick missing");
endmodule

// [bench/adcsq_analog_src.sv]
`timescale 1ns/1ps
module adcsq_analog_src #(parameter int ACQ_CYC = 8) (
    input wire logic ref_clk_in,
    input wire logic [3:0] channel_in,
    input wire logic power_in,
    output logic [9:0] level_out
);
    logic [3:0] last_chan_reg;
    logic [7:0] settle_reg;
    logic [9:0] noise_reg;

    initial
    begin
        last_chan_reg = 4'h0;
        settle_reg = 8'h00;
        noise_reg = 10'h155;
    end

    // ==========================================
    // Hold capacitor charges only after a channel change
    always @(posedge ref_clk_in)
    begin
        noise_reg <= ~noise_reg;
        last_chan_reg <= channel_in;
        if (channel_in != last_chan_reg)
            settle_reg <= 8'(ACQ_CYC);
        else if (settle_reg != 8'h00)
            settle_reg <= settle_reg - 8'h01;
    end

    // Unsettled or unpowered input flips every cycle so a stale sample never passes
    assign level_out = (power_in && settle_reg == 8'h00) ? {channel_in, 6'h15} : noise_reg;
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic special_event_in = 1'b0;
    logic [3:0] compare_mode_in = 4'h0;
    logic [9:0] adc_data;
    logic [7:0] rdata_out;
    logic timer_one_reset_out, converter_power_out, conv_busy_out, vref_sel_out;
    logic irq_out, wake_out, vector_jump_out;
    logic [3:0] channel_out;
    logic [11:0] analog_select_out;
    logic [12:0] vector_addr_out;
    logic [12:0] vec_seen = 13'h0000;
    int n_errors = 0;
    int num_checks = 0;
    int n_wake = 0;
    int n_vec = 0;
    int cnt;
    logic [7:0] ra[8] = '{`ADCSQ_A_INTCTL, `ADCSQ_A_PIRF, `ADCSQ_A_CTL0, `ADCSQ_A_PIE,
                          `ADCSQ_A_ANSLO, `ADCSQ_A_ANSHI, `ADCSQ_A_CTL1, 8'h55};
    logic [7:0] rrv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h00};
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int divs[6] = '{2, 8, 32, 4, 16, 64};

    adcsq_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in),
        .special_event_in(special_event_in), .compare_mode_in(compare_mode_in), .adc_data_in(adc_data),
        .timer_one_reset_out(timer_one_reset_out), .converter_power_out(converter_power_out),
        .conv_busy_out(conv_busy_out), .channel_out(channel_out), .vref_sel_out(vref_sel_out),
        .analog_select_out(analog_select_out), .irq_out(irq_out), .wake_out(wake_out),
        .vector_jump_out(vector_jump_out), .vector_addr_out(vector_addr_out));

    adcsq_analog_src src_u (.ref_clk_in(ref_clk_in), .channel_in(channel_out),
        .power_in(converter_power_out), .level_out(adc_data));

    initial
    begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
    begin
        if (wake_out === 1'b1)
            n_wake++;
        if (vector_jump_out === 1'b1)
        begin
            n_vec++;
            vec_seen = vector_addr_out;
        end
    end

    // ==========================================
    // Access tasks
    task automatic print_verdict();
    begin
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
    begin
        rd(a, d);
        chk($sformatf("register %h", a), {8'h00, d}, {8'h00, e});
    end
    endtask

    // Right justify keeps two bits high; left keeps eight
    task automatic res_chk(input logic [3:0] ch, input logic right);
        logic [7:0] h;
        logic [7:0] l;
        logic [9:0] v;
    begin
        v = {ch, 6'h15};
        rd(`ADCSQ_A_RESH, h);
        rd(`ADCSQ_A_RESL, l);
        chk("result pair", {h, l}, right ? {6'h00, v} : {v, 6'h00});
    end
    endtask

    task automatic wait_idle(output int n);
    begin
        n = 0;
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge ref_clk_in);
            #1;
            if (conv_busy_out === 1'b1)
                n++;
            else if (n > 0)
                return;
        end
        chk("busy timeout", 16'h0001, 16'h0000);
        print_verdict();
    end
    endtask

    // Acquisition and inter-conversion gap are honoured before every start
    task automatic conv(input logic [7:0] c0, output int n);
    begin
        wr(`ADCSQ_A_CTL0, c0);
        repeat (140) @(posedge ref_clk_in);
        wr(`ADCSQ_A_CTL0, c0 | 8'h02);
        wait_idle(n);
    end
    endtask

    task automatic pulse_trigger();
    begin
        @(posedge ref_clk_in);
        special_event_in <= 1'b1;
        @(posedge ref_clk_in);
        special_event_in <= 1'b0;
        #1;
        chk("timer reset", 16'(timer_one_reset_out), 16'h0001);
    end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++)
            rc(ra[i], rrv[i]);
        wr(`ADCSQ_A_CTL1, 8'hff);
        rc(`ADCSQ_A_CTL1, 8'h70);
        wr(`ADCSQ_A_ANSHI, 8'hf3);
        wr(`ADCSQ_A_ANSLO, 8'h5a);
        rc(`ADCSQ_A_ANSHI, 8'h03);
        chk("analog select", 16'(analog_select_out), 16'h035a);
        wr(8'h55, 8'hff);
        rc(8'h55, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            wr(`ADCSQ_A_CTL1, {1'b0, codes[k], 4'h0});
            conv({k[0], 1'b0, 4'(k + 3), 2'b01}, cnt);
            chk("busy cycles", 16'(cnt), 16'(11 * divs[k] + 1));
            chk("channel", 16'(channel_out), 16'(k + 3));
            rc(`ADCSQ_A_CTL0, {k[0], 1'b0, 4'(k + 3), 2'b01});
            res_chk(4'(k + 3), k[0]);
        end
        wr(`ADCSQ_A_RESH, 8'hff);
        wr(`ADCSQ_A_RESL, 8'hff);
        res_chk(4'h8, 1'b1);
        wr(`ADCSQ_A_PIRF, 8'h00);
        rc(`ADCSQ_A_PIRF, 8'h40);
        chk("irq masked", 16'(irq_out), 16'h0000);
        wr(`ADCSQ_A_PIE, 8'h40);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("irq raised", 16'(irq_out), 16'h0001);
        wr(`ADCSQ_A_IRQCLR, 8'h40);
        rc(`ADCSQ_A_PIRF, 8'h00);
        chk("irq cleared", 16'(irq_out), 16'h0000);
        // ==========================================
        // Sleep with the dedicated oscillator
        wr(`ADCSQ_A_CTL1, 8'h30);
        wr(`ADCSQ_A_INTCTL, 8'hc0);
        sleep_in <= 1'b1;
        conv(8'h01, cnt);
        chk("rc start delay", 16'(cnt >= 444 && cnt <= 446), 16'h0001);
        repeat (3) @(posedge ref_clk_in);
        chk("wake count", 16'(n_wake), 16'h0001);
        chk("vector count", 16'(n_vec), 16'h0001);
        chk("vector address", 16'(vec_seen), 16'h0004);
        wr(`ADCSQ_A_INTCTL, 8'h40);
        conv(8'h01, cnt);
        repeat (3) @(posedge ref_clk_in);
        chk("wake without jump", 16'(n_wake * 4 + n_vec), 16'h0009);
        wr(`ADCSQ_A_PIE, 8'h00);
        conv(8'h01, cnt);
        @(posedge ref_clk_in);
        #1;
        chk("sleep power down", 16'(converter_power_out), 16'h0000);
        rc(`ADCSQ_A_CTL0, 8'h01);
        chk("no wake", 16'(n_wake), 16'h0002);
        @(posedge ref_clk_in);
        sleep_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("power back", 16'(converter_power_out), 16'h0001);
        // ==========================================
        // Sleep on the system clock aborts
        wr(`ADCSQ_A_CTL1, 8'h00);
        wr(`ADCSQ_A_CTL0, 8'h03);
        repeat (6) @(posedge ref_clk_in);
        sleep_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("abort busy", 16'({conv_busy_out, converter_power_out}), 16'h0000);
        rc(`ADCSQ_A_CTL0, 8'h01);
        @(posedge ref_clk_in);
        sleep_in <= 1'b0;
        // ==========================================
        // Special event trigger
        compare_mode_in <= `ADCSQ_TRIG_MODE;
        wr(`ADCSQ_A_CTL0, 8'h00);
        pulse_trigger();
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("trigger ignored", 16'(conv_busy_out), 16'h0000);
        wr(`ADCSQ_A_CTL0, 8'h01);
        repeat (140) @(posedge ref_clk_in);
        pulse_trigger();
        wait_idle(cnt);
        chk("trigger conversion", 16'(cnt), 16'd23);
        res_chk(4'h0, 1'b0);
        @(posedge ref_clk_in);
        compare_mode_in <= 4'ha;
        pulse_trigger();
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("wrong mode", 16'(conv_busy_out), 16'h0000);
        // ==========================================
        // Reset in mid conversion keeps the result pair
        wr(`ADCSQ_A_CTL0, 8'hc3);
        repeat (10) @(posedge ref_clk_in);
        #1;
        chk("vref select", 16'({vref_sel_out, channel_out}), 16'h0010);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rc(`ADCSQ_A_CTL0, 8'h00);
        rc(`ADCSQ_A_ANSLO, 8'hff);
        chk("reset abort", 16'({conv_busy_out, converter_power_out}), 16'h0000);
        chk("vref reset", 16'(vref_sel_out), 16'h0000);
        res_chk(4'h0, 1'b0);
        print_verdict();
    end
endmodule
